/* File: hw/sowd_map.svh */
// register map, field positions, reset values and timing counts of the system option block
`ifndef SOWD_MAP_SVH
`define SOWD_MAP_SVH

`define SOWD_ADDR_W            8
`define SOWD_DATA_W            8

`define SOWD_OFS_OPT_ONE       8'h00
`define SOWD_OFS_OPT_TWO       8'h01
`define SOWD_OFS_ID_HIGH       8'h02
`define SOWD_OFS_ID_LOW        8'h03
`define SOWD_OFS_RST_STATUS    8'h04

`define SOWD_O1_TMO_HI         7
`define SOWD_O1_TMO_LO         6
`define SOWD_O1_STOP           5
`define SOWD_O1_WMASK          8'hE3

`define SOWD_O2_CLKSEL         7
`define SOWD_O2_WINDOW         6
`define SOWD_O2_FILT_A         2
`define SOWD_O2_FILT_B         1
`define SOWD_O2_ROUTE          0
`define SOWD_O2_WMASK          8'hC7

`define SOWD_ST_COP            5
`define SOWD_ST_ILLEGAL_OPCODE_FLAG           4

`define SOWD_OPT_ONE_RESET     8'hC0
`define SOWD_OPT_TWO_RESET     8'h00

`define SOWD_SVC_KEY_FIRST     8'h55
`define SOWD_SVC_KEY_SECOND    8'hAA

// arbitrary neutral value
`define SOWD_PART_NUMBER       12'h5A3

`define SOWD_LPO_PERIOD_MS     1
`define SOWD_LPO_TMO_1_MS      32
`define SOWD_LPO_TMO_2_MS      256
`define SOWD_LPO_TMO_3_MS      1024
`define SOWD_LPO_OVF_1         (`SOWD_LPO_TMO_1_MS / `SOWD_LPO_PERIOD_MS)
`define SOWD_LPO_OVF_2         (`SOWD_LPO_TMO_2_MS / `SOWD_LPO_PERIOD_MS)
`define SOWD_LPO_OVF_3         (`SOWD_LPO_TMO_3_MS / `SOWD_LPO_PERIOD_MS)
`define SOWD_BUS_OVF_1         8192
`define SOWD_BUS_OVF_2         65536
`define SOWD_BUS_OVF_3         262144
`define SOWD_BUS_WIN_1         6144
`define SOWD_BUS_WIN_2         49152
`define SOWD_BUS_WIN_3         196608

`endif

/* File: hw/sowd_pkg.sv */
// types shared by the system option and watchdog block
package sowd_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sowd_bus_req_s;

   typedef struct packed {
      logic       watchdog_clock_select;
      logic       watchdog_window_mode;
      logic [1:0] watchdog_timeout_select;
   } sowd_wd_cfg_s;

   typedef struct packed {
      logic stop_permit;
      logic port_a_serial_filter_enable;
      logic port_b_serial_filter_enable;
      logic comparator_to_capture_route;
   } sowd_sys_cfg_s;

   typedef enum logic [0:0] {
      SOWD_SVC_IDLE,
      SOWD_SVC_ARMED
   } sowd_svc_e;

endpackage

/* File: hw/sowd_edge_sync.sv */
// two-flop synchroniser with rising-edge tick for the low-power oscillator pin
`timescale 1ns/1ps
`default_nettype none
module sowd_edge_sync
(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic srst,
   input  wire logic ce,
   // pin side
   input  wire logic pin_in,
   // core side
   output var  logic rise_tick
);
   logic meta;
   logic stable;
   logic prev;

   // meta feeds only stable; edge detect looks at later stages
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         meta      <= 1'b0;
         stable    <= 1'b0;
         prev      <= 1'b0;
         rise_tick <= 1'b0;
      end
      else if (ce)
      begin
         meta      <= pin_in;
         stable    <= meta;
         prev      <= stable;
         rise_tick <= stable & ~prev;
      end
   end
endmodule // sowd_edge_sync
`default_nettype wire

/* File: hw/sowd_wd_counter.sv */
// watchdog up-counter with clear and advance
`timescale 1ns/1ps
`default_nettype none
module sowd_wd_counter
#(
   parameter int CNT_W = 18
)
(
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             srst,
   input  wire logic             ce,
   // control
   input  wire logic             clear,
   input  wire logic             advance,
   // state
   output var  logic [CNT_W-1:0] count
);
   generate
      if (CNT_W < 1)
      begin : g_bad_width
         $error("counter width must be at least one");
      end
   endgenerate

   // clear outranks advance so a service never loses to a tick
   always_ff @(posedge core_clk)
   begin
      if (srst)
         count <= '0;
      else if (ce)
      begin
         if (clear)
            count <= '0;
         else if (advance)
            count <= count + 1'b1;
      end
   end
endmodule // sowd_wd_counter
`default_nettype wire

/* File: hw/sowd_top.sv */
// system option registers, part identity and watchdog of the small controller
//
// Summary of operation
// - option one always readable, bits 3:2 zero
// - option one takes first write only
// - timeout field plus clock select; zero disables
// - oscillator source: 2^5, 2^8 or 2^10 ticks
// - bus source: 2^13, 2^16, 2^18 cycles
// - early status write in window resets device
// - window service is 0x55 then 0xAA
// - bus windows open at 6144/49152/196608 cycles
// - stop forbidden by default; stop forces reset only while option one bit 5 is clear
// - option two clock/window bits write once
// - bits 2,1 enable serial port filters
// - bit 0 routes comparator to capture
// - identity reserved bits, writes ignored
// - twelve-bit hard-coded part number readable
// - normal mode: any status write clears counter
// - timeout resets device, sets sticky cause flag
`include "sowd_map.svh"
`timescale 1ns/1ps
`default_nettype none
module sowd_top
#(
   parameter int CNT_W      = 18,
   parameter int LPO_OVF_1  = `SOWD_LPO_OVF_1,
   parameter int LPO_OVF_2  = `SOWD_LPO_OVF_2,
   parameter int LPO_OVF_3  = `SOWD_LPO_OVF_3,
   parameter int BUS_OVF_1  = `SOWD_BUS_OVF_1,
   parameter int BUS_OVF_2  = `SOWD_BUS_OVF_2,
   parameter int BUS_OVF_3  = `SOWD_BUS_OVF_3,
   parameter int BUS_WIN_1  = `SOWD_BUS_WIN_1,
   parameter int BUS_WIN_2  = `SOWD_BUS_WIN_2,
   parameter int BUS_WIN_3  = `SOWD_BUS_WIN_3
)
(
   // clock, reset, enable
   input  wire logic                    core_clk,
   input  wire logic                    srst,
   input  wire logic                    ce,
   input  wire logic                    por_clear,
   // register port
   input  wire sowd_pkg::sowd_bus_req_s bus_req,
   output var  logic [7:0]              rdata,
   // pins and core events
   input  wire logic                    lpo_clk_pin,
   input  wire logic                    stop_exec,
   // configuration out
   output var  sowd_pkg::sowd_wd_cfg_s  wd_cfg,
   output var  sowd_pkg::sowd_sys_cfg_s sys_cfg,
   // reset requests
   output var  logic                    wd_reset_req,
   output var  logic                    illegal_opcode_flag_reset_req
);
   import sowd_pkg::*;

   localparam int CW = CNT_W + 1;

   generate
      if (BUS_OVF_3 > 2**CNT_W || LPO_OVF_3 > 2**CNT_W)
      begin : g_bad_cnt
         $error("counter too narrow for the longest timeout");
      end
      if (BUS_WIN_1 >= BUS_OVF_1 || BUS_WIN_2 >= BUS_OVF_2 || BUS_WIN_3 >= BUS_OVF_3)
      begin : g_bad_win
         $error("window must open before overflow");
      end
      if (LPO_OVF_1 < 2 || BUS_OVF_1 < 2)
      begin : g_bad_ovf
         $error("overflow counts must be at least two");
      end
   endgenerate

   // overflow count for the selected source and code
   function automatic logic [CW-1:0] wd_limit(input logic csel, input logic [1:0] tmo);
      logic [CW-1:0] lim;
      lim = '0;
      case ({csel, tmo})
         3'b001:  lim = CW'(LPO_OVF_1);
         3'b010:  lim = CW'(LPO_OVF_2);
         3'b011:  lim = CW'(LPO_OVF_3);
         3'b101:  lim = CW'(BUS_OVF_1);
         3'b110:  lim = CW'(BUS_OVF_2);
         3'b111:  lim = CW'(BUS_OVF_3);
         default: lim = '0;
      endcase
      return lim;
   endfunction

   // elapsed count at which the service window opens
   function automatic logic [CW-1:0] wd_window(input logic [1:0] tmo);
      logic [CW-1:0] w;
      w = '0;
      case (tmo)
         2'b01:   w = CW'(BUS_WIN_1);
         2'b10:   w = CW'(BUS_WIN_2);
         2'b11:   w = CW'(BUS_WIN_3);
         default: w = '0;
      endcase
      return w;
   endfunction

   logic [7:0]       opt_one;
   logic [7:0]       opt_two;
   logic             opt_one_done;
   logic             opt_two_done;
   logic             cop_cause;
   logic             illegal_opcode_flag_cause;
   logic             status_cop;
   logic             status_illegal_opcode_flag;
   logic             srst_seen;
   sowd_svc_e        svc_state;
   sowd_svc_e        next_svc;
   logic [CNT_W-1:0] wd_count;
   logic             lpo_tick;

   // address decode
   wire hit_one    = bus_req.addr == `SOWD_OFS_OPT_ONE;
   wire hit_two    = bus_req.addr == `SOWD_OFS_OPT_TWO;
   wire hit_idh    = bus_req.addr == `SOWD_OFS_ID_HIGH;
   wire hit_idl    = bus_req.addr == `SOWD_OFS_ID_LOW;
   wire hit_status = bus_req.addr == `SOWD_OFS_RST_STATUS;
   wire wr_one     = bus_req.wr && hit_one && !opt_one_done;
   wire wr_two     = bus_req.wr && hit_two && !opt_two_done;
   wire svc_wr     = bus_req.wr && hit_status;

   // watchdog configuration
   wire [1:0]    tmo_sel    = opt_one[`SOWD_O1_TMO_HI:`SOWD_O1_TMO_LO];
   wire          clk_sel    = opt_two[`SOWD_O2_CLKSEL];
   wire          win_mode   = opt_two[`SOWD_O2_WINDOW];
   wire          wd_enabled = tmo_sel != 2'b00;
   // windowing only exists for the bus source; oscillator codes ignore it
   wire          win_active = win_mode && clk_sel && wd_enabled;
   wire          advance    = wd_enabled && (clk_sel || lpo_tick);
   wire [CW-1:0] limit      = wd_limit(clk_sel, tmo_sel);
   wire [CW-1:0] win_open   = wd_window(tmo_sel);
   wire [CW-1:0] cnt_ext    = {1'b0, wd_count};
   wire          timeout    = advance && (cnt_ext == limit - 1'b1);

   // window servicing
   wire early     = win_active && (cnt_ext < win_open);
   wire violation = svc_wr && early;
   wire key_one   = bus_req.wdata == `SOWD_SVC_KEY_FIRST;
   wire key_two   = bus_req.wdata == `SOWD_SVC_KEY_SECOND;
   wire win_svc   = svc_wr && win_active && !early && svc_state == SOWD_SVC_ARMED && key_two;
   wire norm_svc  = svc_wr && !win_active;
   wire wd_clear  = norm_svc || win_svc || violation || timeout;
   wire wd_fire   = timeout || violation;
   wire stop_bad  = stop_exec && !opt_one[`SOWD_O1_STOP];

   // the 0x55 key arms; anything else in the window disarms, and clears only if it is 0xAA while armed
   always_comb
   begin
      next_svc = svc_state;
      if (svc_wr)
      begin
         if (!win_active || early)
            next_svc = SOWD_SVC_IDLE;
         else if (key_one)
            next_svc = SOWD_SVC_ARMED;
         else
            next_svc = SOWD_SVC_IDLE;
      end
   end

   // read selection; unmapped and reserved bits read zero
   wire [7:0] id_high = {4'h0, 4'(`SOWD_PART_NUMBER >> 8)};
   wire [7:0] id_low  = 8'(`SOWD_PART_NUMBER);
   wire [7:0] status  = {2'b00, status_cop, status_illegal_opcode_flag, 4'h0};
   wire [7:0] rd_mux  = hit_one    ? (opt_one & `SOWD_O1_WMASK) :
                        hit_two    ? (opt_two & `SOWD_O2_WMASK) :
                        hit_idh    ? id_high :
                        hit_idl    ? id_low :
                        hit_status ? status : 8'h00;

   sowd_edge_sync u_lpo_sync
   (
      .core_clk  (core_clk),
      .srst      (srst),
      .ce        (ce),
      .pin_in    (lpo_clk_pin),
      .rise_tick (lpo_tick)
   );

   sowd_wd_counter #(.CNT_W(CNT_W)) u_counter
   (
      .core_clk (core_clk),
      .srst     (srst),
      .ce       (ce),
      .clear    (wd_clear),
      .advance  (advance),
      .count    (wd_count)
   );

   // write-once option registers; the first write is honoured even if it
   // equals the reset value, so boot code must always write them
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         opt_one      <= `SOWD_OPT_ONE_RESET;
         opt_one_done <= 1'b0;
      end
      else if (ce && wr_one)
      begin
         opt_one      <= bus_req.wdata & `SOWD_O1_WMASK;
         opt_one_done <= 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         opt_two      <= `SOWD_OPT_TWO_RESET;
         opt_two_done <= 1'b0;
      end
      else if (ce && wr_two)
      begin
         opt_two      <= bus_req.wdata & `SOWD_O2_WMASK;
         opt_two_done <= 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         svc_state <= SOWD_SVC_IDLE;
      else if (ce)
         svc_state <= next_svc;
   end

   // causes are wiped by srst as well as power-on; the status captures them on the first srst cycle
   always_ff @(posedge core_clk)
   begin
      if (por_clear || srst)
      begin
         cop_cause  <= 1'b0;
         illegal_opcode_flag_cause <= 1'b0;
      end
      else if (ce)
      begin
         cop_cause  <= cop_cause | wd_fire;
         illegal_opcode_flag_cause <= illegal_opcode_flag_cause | stop_bad;
      end
   end

   always_ff @(posedge core_clk)
   begin
      srst_seen <= srst;
      if (por_clear)
      begin
         status_cop  <= 1'b0;
         status_illegal_opcode_flag <= 1'b0;
      end
      else if (srst && !srst_seen)
      begin
         status_cop  <= cop_cause;
         status_illegal_opcode_flag <= illegal_opcode_flag_cause;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         wd_reset_req   <= 1'b0;
         illegal_opcode_flag_reset_req <= 1'b0;
         rdata          <= 8'h00;
      end
      else if (ce)
      begin
         wd_reset_req   <= wd_fire;
         illegal_opcode_flag_reset_req <= stop_bad;
         rdata          <= bus_req.rd ? rd_mux : 8'h00;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         wd_cfg  <= '0;
         sys_cfg <= '0;
      end
      else if (ce)
      begin
         wd_cfg  <= {clk_sel, win_mode, tmo_sel};
         sys_cfg <= {opt_one[`SOWD_O1_STOP], opt_two[`SOWD_O2_FILT_A],
                     opt_two[`SOWD_O2_FILT_B], opt_two[`SOWD_O2_ROUTE]};
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   AST_OPT1_RSV_ZERO: assert property (ce && bus_req.rd && hit_one |=> rdata[3:2] == 2'b00)
      else $error("reserved option bits read nonzero");
   AST_OPT1_ONCE: assert property (ce && opt_one_done |=> $stable(opt_one))
      else $error("option one changed after first write");
   AST_OPT2_ONCE: assert property (opt_two_done |=> opt_two_done && $stable(opt_two))
      else $error("option two changed after first write");
   AST_WD_DISABLED: assert property (ce && tmo_sel == 2'b00 && !svc_wr
                                     |=> $stable(wd_count) && !wd_reset_req)
      else $error("disabled watchdog moved");
   AST_LPO_TIMEOUT: assert property (ce && !clk_sel && tmo_sel == 2'b10 && lpo_tick
                                     && wd_count == 18'h000FF |=> wd_reset_req)
      else $error("oscillator timeout missed at 256");
   AST_BUS_TIMEOUT: assert property (ce && clk_sel && tmo_sel == 2'b01 && !svc_wr
                                     && wd_count == 18'h01FFF |=> wd_reset_req ##1 !wd_reset_req)
      else $error("bus timeout not a single pulse at 8192");
   AST_WIN_EARLY: assert property (ce && win_mode && clk_sel && tmo_sel == 2'b01 && svc_wr
                                   && wd_count < 18'h01800 |=> wd_reset_req)
      else $error("early service write did not reset");
   AST_WIN_SERVICE: assert property (ce && win_active && svc_wr && key_one && !early ##1
                                     ce && svc_wr && key_two |=> wd_count == '0)
      else $error("window service sequence did not clear");
   AST_NORMAL_CLEAR: assert property (ce && svc_wr && !win_active |=> wd_count == '0 && !wd_reset_req)
      else $error("normal service write did not clear");
   AST_STOP_ILLEGAL: assert property (ce && stop_exec && !opt_one[`SOWD_O1_STOP] |=> illegal_opcode_flag_reset_req)
      else $error("forbidden stop did not reset");
   AST_ID_READ: assert property (ce && bus_req.rd && hit_idh
                                 |=> rdata == 8'(`SOWD_PART_NUMBER >> 8))
      else $error("identity high read wrong");
   AST_CAUSE_FLAG: assert property (disable iff (por_clear) $rose(srst)
                                    |=> status_cop == $past(cop_cause))
      else $error("timeout cause flag wrong after reset");
   COV_WIN_SERVICE: cover property (win_svc);
   COV_TIMEOUT: cover property (timeout);
   COV_VIOLATION: cover property (violation);
   COV_STOP_BAD: cover property (stop_bad);
endmodule // sowd_top
`default_nettype wire

/* File: dv/test_sowd_top.sv */
// self-checking testbench of the system option and watchdog block
`timescale 1ns/1ps
`default_nettype none
`include "sowd_map.svh"
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin miscompares++; \
   $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module test_sowd_top;
   import sowd_pkg::*;
   logic                    core_clk;
   logic                    srst;
   logic                    ce;
   logic                    por_clear;
   sowd_bus_req_s           bus_req;
   logic [7:0]              rdata;
   logic                    lpo_clk_pin;
   logic                    stop_exec;
   sowd_wd_cfg_s            wd_cfg;
   sowd_sys_cfg_s           sys_cfg;
   logic                    wd_reset_req;
   logic                    illegal_opcode_flag_reset_req;
   logic                    lpo_run;
   logic [7:0]              o1_m;
   logic [7:0]              o2_m;
   logic [7:0]              st_m;
   logic [7:0]              r1;
   logic [7:0]              r2;
   logic                    w1_m;
   logic                    w2_m;
   logic                    cop_m;
   logic                    illegal_opcode_flag_m;
   int                      miscompares = 0;
   int                      n_tests = 0;
   int                      cyc = 0;
   int                      t0;

   sowd_top sowd_top_i
   (
      .core_clk       (core_clk),
      .srst           (srst),
      .ce             (ce),
      .por_clear      (por_clear),
      .bus_req        (bus_req),
      .rdata          (rdata),
      .lpo_clk_pin    (lpo_clk_pin),
      .stop_exec      (stop_exec),
      .wd_cfg         (wd_cfg),
      .sys_cfg        (sys_cfg),
      .wd_reset_req   (wd_reset_req),
      .illegal_opcode_flag_reset_req (illegal_opcode_flag_reset_req)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // oscillator pin runs far faster than 1 kHz so oscillator timeouts fit the run
   initial
   begin
      lpo_clk_pin = 1'b0;
      forever #200 lpo_clk_pin = lpo_run ? ~lpo_clk_pin : 1'b0;
   end

   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 45000)
      begin
         miscompares++;
         test_done();
      end
   end

   task automatic test_done();
      if (miscompares == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
      #1;
      if (a == `SOWD_OFS_OPT_ONE && !w1_m)
      begin
         o1_m = d & `SOWD_O1_WMASK;
         w1_m = 1'b1;
      end
      if (a == `SOWD_OFS_OPT_TWO && !w2_m)
      begin
         o2_m = d & `SOWD_O2_WMASK;
         w2_m = 1'b1;
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      #1;
      `CHK("rdata", ex, rdata)
   endtask

   // 0x55 and the second key on back-to-back cycles
   task automatic svc_pair(input logic [7:0] d2);
      @(posedge core_clk);
      bus_req <= '{addr: `SOWD_OFS_RST_STATUS, wdata: `SOWD_SVC_KEY_FIRST, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus_req.wdata <= d2;
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
      #1;
   endtask

   // two reset edges: status must keep what the first edge captured
   task automatic rst1();
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      #1;
      st_m = {2'b00, cop_m, illegal_opcode_flag_m, 4'h0};
      {cop_m, illegal_opcode_flag_m, w1_m, w2_m} = 4'h0;
      o1_m = `SOWD_OPT_ONE_RESET;
      o2_m = `SOWD_OPT_TWO_RESET;
   endtask

   task automatic all_chk();
      rd_chk(`SOWD_OFS_OPT_ONE, o1_m);
      rd_chk(`SOWD_OFS_OPT_TWO, o2_m);
      rd_chk(`SOWD_OFS_ID_HIGH, {4'h0, 4'(`SOWD_PART_NUMBER >> 8)});
      rd_chk(`SOWD_OFS_ID_LOW, 8'(`SOWD_PART_NUMBER));
      rd_chk(`SOWD_OFS_RST_STATUS, st_m);
      `CHK("wd_cfg", {o2_m[7:6], o1_m[7:6]}, wd_cfg)
      `CHK("sys_cfg", {o1_m[5], o2_m[2:0]}, sys_cfg)
   endtask

   task automatic quiet(input int n);
      int bad;
      bad = 0;
      repeat (n)
      begin
         @(posedge core_clk);
         #1;
         if (wd_reset_req !== 1'b0)
            bad++;
      end
      `CHK("no_timeout", 0, bad)
   endtask

   task automatic wait_req(input int limit);
      int k;
      k = 0;
      while (wd_reset_req !== 1'b1 && k < limit)
      begin
         @(posedge core_clk);
         #1;
         k++;
      end
   endtask

   task automatic stop_chk(input logic ex);
      @(posedge core_clk);
      stop_exec <= 1'b1;
      @(posedge core_clk);
      stop_exec <= 1'b0;
      #1;
      `CHK("illegal_opcode_flag_req", ex, illegal_opcode_flag_reset_req)
   endtask

   initial
   begin
      void'($urandom(91786));
      srst = 1'b1;
      por_clear = 1'b1;
      ce = 1'b1;
      stop_exec = 1'b0;
      lpo_run = 1'b1;
      bus_req = '0;
      {cop_m, illegal_opcode_flag_m, w1_m, w2_m} = 4'h0;
      st_m = 8'h00;
      o1_m = `SOWD_OPT_ONE_RESET;
      o2_m = `SOWD_OPT_TWO_RESET;
      repeat (6) @(posedge core_clk);
      srst <= 1'b0;
      por_clear <= 1'b0;
      #1;
      all_chk();
      // watchdog off, random options, repeated writes must be ignored
      r1 = (8'($urandom) & 8'h0F) | 8'h20;
      r2 = 8'($urandom) & 8'h07;
      wr(`SOWD_OFS_OPT_ONE, r1);
      wr(`SOWD_OFS_OPT_ONE, 8'hFF);
      wr(`SOWD_OFS_OPT_TWO, r2);
      wr(`SOWD_OFS_OPT_TWO, 8'hC7);
      wr(`SOWD_OFS_ID_HIGH, 8'hFF);
      wr(`SOWD_OFS_ID_LOW, 8'hFF);
      wr(8'h07, 8'hFF);
      all_chk();
      rd_chk(8'h07, 8'h00);
      quiet(300);
      stop_chk(1'b0);
      // bus clock, code 01, normal mode
      rst1();
      all_chk();
      wr(`SOWD_OFS_OPT_ONE, 8'h40);
      wr(`SOWD_OFS_OPT_TWO, 8'h80);
      stop_chk(1'b1);
      illegal_opcode_flag_m = 1'b1;
      wr(`SOWD_OFS_RST_STATUS, 8'($urandom));
      quiet(5000);
      wr(`SOWD_OFS_RST_STATUS, 8'($urandom));
      t0 = cyc;
      wait_req(9000);
      `CHK("timeout_cycles", `SOWD_BUS_OVF_1, cyc - t0)
      cop_m = 1'b1;
      rst1();
      all_chk();
      // window mode: early write, then good and broken service pairs
      lpo_run = 1'b0;
      rst1();
      wr(`SOWD_OFS_OPT_TWO, 8'hC0);
      wr(`SOWD_OFS_OPT_ONE, 8'h40);
      wr(`SOWD_OFS_RST_STATUS, `SOWD_SVC_KEY_FIRST);
      `CHK("early_req", 1'b1, wd_reset_req)
      cop_m = 1'b1;
      rst1();
      all_chk();
      wr(`SOWD_OFS_OPT_TWO, 8'hC0);
      wr(`SOWD_OFS_OPT_ONE, 8'h40);
      quiet(`SOWD_BUS_WIN_1 + 150);
      svc_pair(`SOWD_SVC_KEY_SECOND);
      t0 = cyc;
      `CHK("late_req", 1'b0, wd_reset_req)
      quiet(`SOWD_BUS_WIN_1 + 150);
      svc_pair(8'h12);
      wait_req(3000);
      `CHK("window_cycles", `SOWD_BUS_OVF_1, cyc - t0)
      cop_m = 1'b1;
      rst1();
      all_chk();
      // oscillator source, code 10; window bit has no effect here
      lpo_run = 1'b1;
      wr(`SOWD_OFS_OPT_TWO, 8'h40 | (8'($urandom) & 8'h07));
      wr(`SOWD_OFS_OPT_ONE, 8'h80);
      wr(`SOWD_OFS_RST_STATUS, 8'h00);
      t0 = cyc;
      wait_req(3000);
      `CHK("lpo_timeout", 1'b1, (cyc - t0 >= 2040 && cyc - t0 <= 2064))
      cop_m = 1'b1;
      rst1();
      all_chk();
      // oscillator source, shortest code 01
      wr(`SOWD_OFS_OPT_TWO, 8'($urandom) & 8'h07);
      wr(`SOWD_OFS_OPT_ONE, 8'h40);
      wr(`SOWD_OFS_RST_STATUS, 8'($urandom));
      t0 = cyc;
      wait_req(400);
      `CHK("lpo_short", 1'b1, (cyc - t0 >= 8 * `SOWD_LPO_OVF_1 - 8 && cyc - t0 <= 8 * `SOWD_LPO_OVF_1 + 16))
      cop_m = 1'b1;
      rst1();
      all_chk();
      test_done();
   end
endmodule // test_sowd_top
`default_nettype wire
